/* File: pkg/spi_eeprom_defs.vh */
/*
 * Constants of the SPI EEPROM instruction engine: opcodes, status bit
 * positions, address-space codes and the self-timed write cycle length.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SPI_EEPROM_DEFS_VH
`define SPI_EEPROM_DEFS_VH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OPC_SET_WRITE_LATCH   8'h06
`define OPC_CLEAR_WRITE_LATCH 8'h04
`define OPC_STATUS_READ       8'h05
`define OPC_STATUS_WRITE      8'h01
`define OPC_ARRAY_READ        8'h03
`define OPC_ARRAY_WRITE       8'h02
`define OPC_EXT_READ          8'h83
`define OPC_EXT_WRITE         8'h82

// ----------------------------------------------------------------------
// status register layout
// ----------------------------------------------------------------------
`define ST_BUSY_BIT           0
`define ST_LATCH_BIT          1
`define ST_PROT_LO_BIT        2
`define ST_PROT_HI_BIT        3
`define ST_LOCK_BIT           7
`define ST_LOCK_RESET         1'b0
`define ST_PROT_RESET         2'h0
`define LOCK_STATUS_BIT       1

// ----------------------------------------------------------------------
// address spaces
// ----------------------------------------------------------------------
`define SPACE_ARRAY           2'h0
`define SPACE_SECTOR          2'h1
`define SPACE_UID             2'h2
`define SPACE_LOCK            2'h3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_FREQ_MHZ          200
`define SELF_TIMED_CYCLE_TIME_US 5000
`define BUSY_CNT_W            20
`define WRITE_CYCLE_CYCLES    (`SELF_TIMED_CYCLE_TIME_US * `CLK_FREQ_MHZ)

// ----------------------------------------------------------------------
// synchroniser
// ----------------------------------------------------------------------
`define SYNC_W                4
`define SYNC_RESET            4'hA

`endif

/* File: hw/pin_sync.v */
/*
 * Two-flop synchroniser for the serial pins: bit 0 clock, bit 1 select,
 * bit 2 data in, bit 3 write protect.
 * Assumes pins asynchronous to clk_i; select and protect idle high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_defs.vh"

module pin_sync (
    input  wire                 clk_i,
    input  wire                 rst_b_i,
    input  wire                 ce_i,
    input  wire [`SYNC_W-1:0]   d_i,
    output wire [`SYNC_W-1:0]   q_o
);
    reg [`SYNC_W-1:0] meta_q;
    reg [`SYNC_W-1:0] sync_q;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= `SYNC_RESET;
            sync_q <= `SYNC_RESET;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule
`default_nettype wire

/* File: hw/spi_eeprom_instruction_engine.v */
/*
 * Instruction decoder and sequencer of an SPI serial EEPROM on an oversampling clock.
 * Assumes an outside store read asynchronously and a page programmer fed by strobes.
 */
// Overview of operation
// - frame starts at select fall, opcode first
// - select rise ends any instruction
// - write frames off byte boundary are discarded
// - busy: only status read accepted
// - opcodes 06h, 04h, 05h
// - opcodes 01h, 03h, 02h
// - 83h extended reads, 82h extended writes
// - address bits 10:9 pick sector, lock, UID
// - set latch command sets latch bit
// - writes refused while latch is zero
// - clear command, power-up, write end clear latch
// - status shifted out repeatedly, MSB first
// - status read accepted even while busy
// - status write changes only lock, protect bits
// - status write needs exactly one data byte
// - status write starts timed busy cycle
// - array read streams bytes, address increments
// - array read ignored while busy
// - array write: opcode, address, 1-64 bytes
// - page index wraps within 64 bytes
// - whole last byte needed, then busy cycle
// - writes into protected range not executed
// - protect levels quarter, half, all, none
// - status bits busy, latch, protect positions
// - status lock plus low protect refuses status write
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_defs.vh"

module spi_eeprom_instruction_engine #(
    parameter [`BUSY_CNT_W-1:0] WRITE_CYCLE_CYCLES = `WRITE_CYCLE_CYCLES
) (
    input  wire        clk_i,
    input  wire        rst_b_i,
    input  wire        ce_i,
    input  wire        spi_clk_i,
    input  wire        cs_b_i,
    input  wire        serial_in_i,
    input  wire        wp_b_i,
    output wire        serial_out_o,
    output wire        serial_out_oe_o,
    output wire [15:0] mem_addr_o,
    output wire [1:0]  mem_space_o,
    input  wire [7:0]  mem_rd_data_i,
    input  wire        sector_locked_i,
    output wire        page_load_o,
    output wire [5:0]  page_load_idx_o,
    output wire [7:0]  page_load_data_o,
    output wire        page_commit_o,
    output wire        page_abort_o,
    output wire        sector_lock_o,
    output wire [7:0]  status_o
);
    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [9:0] S_OPC  = 10'h001;
    localparam [9:0] S_SET  = 10'h002;
    localparam [9:0] S_CLR  = 10'h004;
    localparam [9:0] S_STATUS_READ_CMD = 10'h008;
    localparam [9:0] S_STATUS_WRITE_CMD = 10'h010;
    localparam [9:0] S_RD   = 10'h020;
    localparam [9:0] S_WR   = 10'h040;
    localparam [9:0] S_XRD  = 10'h080;
    localparam [9:0] S_XWR  = 10'h100;
    localparam [9:0] S_IGN  = 10'h200;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function [1:0] space_of;
        input [15:0] a;
        begin
            if (a[9])
                space_of = `SPACE_UID;
            else if (a[10])
                space_of = `SPACE_LOCK;
            else
                space_of = `SPACE_SECTOR;
        end
    endfunction
    function is_protected;
        input [1:0]  bp;
        input [15:0] a;
        begin
            case (bp)
                2'h1:    is_protected = (a[13:12] == 2'h3);
                2'h2:    is_protected = a[13];
                2'h3:    is_protected = 1'b1;
                default: is_protected = 1'b0;
            endcase
        end
    endfunction
    function [15:0] next_addr;
        input [1:0]  sp;
        input [15:0] a;
        begin
            case (sp)
                `SPACE_SECTOR: next_addr = {a[15:6], a[5:0] + 6'h01};
                `SPACE_UID:    next_addr = {a[15:4], a[3:0] + 4'h1};
                `SPACE_LOCK:   next_addr = a;
                default:       next_addr = a + 16'h0001;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------------
    wire [`SYNC_W-1:0] pins_s;

    pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .d_i     ({wp_b_i, serial_in_i, cs_b_i, spi_clk_i}),
        .q_o     (pins_s)
    );

    wire sclk_s = pins_s[0];
    wire cs_b_s = pins_s[1];
    wire si_s   = pins_s[2];
    wire wp_b_s = pins_s[3];

    reg                  sclk_prev_q;
    reg                  cs_b_prev_q;
    reg  [9:0]           st_q;
    reg  [2:0]           bit_q;
    reg  [2:0]           byte_q;
    reg  [6:0]           sh_q;
    reg  [15:0]          addr_q;
    reg  [1:0]           space_q;
    reg  [5:0]           idx_q;
    reg  [7:0]           data_q;
    reg  [7:0]           out_byte_q;
    reg                  load_pend_q;
    reg                  out_q;
    reg                  oe_q;
    reg                  wel_q;
    reg                  lock_q;
    reg  [1:0]           bp_q;
    reg  [`BUSY_CNT_W-1:0] busy_cnt_q;
    reg                  load_q;
    reg                  commit_q;
    reg                  abort_q;
    reg                  slock_q;

    wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_b_s;
    wire sclk_fall = ~sclk_s & sclk_prev_q & ~cs_b_s;
    wire cs_rise   = cs_b_s & ~cs_b_prev_q;
    wire byte_done = sclk_rise & (bit_q == 3'h7);
    wire [7:0] byte_in = {sh_q, si_s};
    wire busy      = (busy_cnt_q != {`BUSY_CNT_W{1'b0}});
    wire whole     = (bit_q == 3'h0);
    wire [15:0] addr_in = {addr_q[7:0], byte_in};
    wire [7:0] status;
    assign status[`ST_LOCK_BIT]    = lock_q;
    assign status[6:4]             = 3'h0;
    assign status[`ST_PROT_HI_BIT] = bp_q[1];
    assign status[`ST_PROT_LO_BIT] = bp_q[0];
    assign status[`ST_LATCH_BIT]   = wel_q;
    assign status[`ST_BUSY_BIT]    = busy;
    wire out_phase = (st_q == S_STATUS_READ_CMD) |
                     (((st_q == S_RD) | (st_q == S_XRD)) & (byte_q >= 3'h3));

    // ------------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------------
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_prev_q <= 1'b0;
            cs_b_prev_q <= 1'b1;
            st_q        <= S_OPC;
            bit_q       <= 3'h0;
            byte_q      <= 3'h0;
            sh_q        <= 7'h00;
            addr_q      <= 16'h0000;
            space_q     <= `SPACE_ARRAY;
            idx_q       <= 6'h00;
            data_q      <= 8'h00;
            out_byte_q  <= 8'h00;
            load_pend_q <= 1'b0;
            out_q       <= 1'b0;
            oe_q        <= 1'b0;
            wel_q       <= 1'b0;
            lock_q      <= `ST_LOCK_RESET;
            bp_q        <= `ST_PROT_RESET;
            busy_cnt_q  <= {`BUSY_CNT_W{1'b0}};
            load_q      <= 1'b0;
            commit_q    <= 1'b0;
            abort_q     <= 1'b0;
            slock_q     <= 1'b0;
        end else if (ce_i) begin
            sclk_prev_q <= sclk_s;
            cs_b_prev_q <= cs_b_s;
            load_q      <= 1'b0;
            commit_q    <= 1'b0;
            abort_q     <= 1'b0;
            slock_q     <= 1'b0;
            load_pend_q <= 1'b0;
            if (busy) begin
                busy_cnt_q <= busy_cnt_q - {{(`BUSY_CNT_W-1){1'b0}}, 1'b1};
                if (busy_cnt_q == {{(`BUSY_CNT_W-1){1'b0}}, 1'b1})
                    wel_q <= 1'b0;
            end
            // read data fetch one cycle after the byte boundary
            if (load_pend_q) begin
                if (space_q == `SPACE_LOCK)
                    out_byte_q <= {6'h00, sector_locked_i, 1'b0};
                else
                    out_byte_q <= mem_rd_data_i;
                addr_q <= next_addr(space_q, addr_q);
            end
            if (sclk_rise) begin
                sh_q  <= byte_in[6:0];
                bit_q <= bit_q + 3'h1;
            end
            if (byte_done) begin
                if (byte_q != 3'h7)
                    byte_q <= byte_q + 3'h1;
                if (byte_q == 3'h0) begin
                    space_q <= `SPACE_ARRAY;
                    if (busy && byte_in != `OPC_STATUS_READ) begin
                        st_q <= S_IGN;
                    end else begin
                        case (byte_in)
                            `OPC_SET_WRITE_LATCH:   st_q <= S_SET;
                            `OPC_CLEAR_WRITE_LATCH: st_q <= S_CLR;
                            `OPC_STATUS_READ: begin
                                st_q       <= S_STATUS_READ_CMD;
                                out_byte_q <= status;
                            end
                            `OPC_STATUS_WRITE:
                                st_q <= (wel_q && !(lock_q && !wp_b_s)) ?
                                        S_STATUS_WRITE_CMD : S_IGN;
                            `OPC_ARRAY_READ:  st_q <= S_RD;
                            `OPC_ARRAY_WRITE: st_q <= wel_q ? S_WR : S_IGN;
                            `OPC_EXT_READ:    st_q <= S_XRD;
                            `OPC_EXT_WRITE:
                                st_q <= (wel_q && bp_q != 2'h3 && !sector_locked_i) ?
                                        S_XWR : S_IGN;
                            default:          st_q <= S_IGN;
                        endcase
                    end
                end else if (st_q == S_STATUS_READ_CMD) begin
                    out_byte_q <= status;
                end else if (byte_q <= 3'h2) begin
                    addr_q <= addr_in;
                    if (st_q == S_STATUS_WRITE_CMD)
                        data_q <= byte_in;
                    if (byte_q == 3'h2) begin
                        idx_q <= byte_in[5:0];
                        if (st_q == S_XRD || st_q == S_XWR)
                            space_q <= space_of(addr_in);
                        if (st_q == S_RD || st_q == S_XRD)
                            load_pend_q <= 1'b1;
                        if (st_q == S_WR && is_protected(bp_q, addr_in))
                            st_q <= S_IGN;
                        if (st_q == S_XWR && space_of(addr_in) == `SPACE_UID)
                            st_q <= S_IGN;
                    end
                end else begin
                    if (st_q == S_RD || st_q == S_XRD)
                        load_pend_q <= 1'b1;
                    if (st_q == S_WR ||
                        (st_q == S_XWR && space_q == `SPACE_SECTOR)) begin
                        load_q <= 1'b1;
                        idx_q  <= idx_q + 6'h01;
                    end
                    data_q <= byte_in;
                end
            end
            if (sclk_fall && out_phase) begin
                out_q <= out_byte_q[~bit_q];
                oe_q  <= 1'b1;
            end
            if (cs_rise) begin
                case (st_q)
                    S_SET:
                        if (byte_q == 3'h1 && whole)
                            wel_q <= 1'b1;
                    S_CLR:
                        if (byte_q == 3'h1 && whole)
                            wel_q <= 1'b0;
                    S_STATUS_WRITE_CMD:
                        if (byte_q == 3'h2 && whole) begin
                            lock_q     <= data_q[`ST_LOCK_BIT];
                            bp_q       <= data_q[`ST_PROT_HI_BIT:`ST_PROT_LO_BIT];
                            busy_cnt_q <= WRITE_CYCLE_CYCLES;
                        end
                    S_WR, S_XWR: begin
                        if (st_q == S_WR || space_q == `SPACE_SECTOR) begin
                            if (byte_q >= 3'h4 && whole) begin
                                commit_q   <= 1'b1;
                                busy_cnt_q <= WRITE_CYCLE_CYCLES;
                            end else if (byte_q >= 3'h4) begin
                                abort_q <= 1'b1;
                            end
                        end else if (byte_q == 3'h4 && whole &&
                                     data_q[`LOCK_STATUS_BIT]) begin
                            slock_q    <= 1'b1;
                            busy_cnt_q <= WRITE_CYCLE_CYCLES;
                        end
                    end
                    default: ;
                endcase
            end
            if (cs_b_s) begin
                st_q   <= S_OPC;
                bit_q  <= 3'h0;
                byte_q <= 3'h0;
                oe_q   <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign serial_out_o     = out_q;
    assign serial_out_oe_o  = oe_q;
    assign mem_addr_o       = addr_q;
    assign mem_space_o      = space_q;
    assign page_load_o      = load_q;
    assign page_load_idx_o  = idx_q - 6'h01;
    assign page_load_data_o = data_q;
    assign page_commit_o    = commit_q;
    assign page_abort_o     = abort_q;
    assign sector_lock_o    = slock_q;
    assign status_o         = status;
endmodule
`default_nettype wire

/* File: bench/spi_eeprom_instruction_engine_monitor.sv */
/*
 * Concurrent checks on the ports of the instruction engine.
 * Assumes one clock domain and the busy count handed on by the bind.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_instruction_engine_monitor #(
    parameter int WRITE_CYCLE_CYCLES = 1000000
) (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        cs_b_i,
    input wire logic        serial_out_oe_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [1:0]  mem_space_o,
    input wire logic        page_load_o,
    input wire logic        page_commit_o,
    input wire logic        page_abort_o,
    input wire logic [7:0]  status_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic [31:0] busy_cnt_q;
    logic        prot;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) busy_cnt_q <= '0;
        else busy_cnt_q <= status_o[0] ? busy_cnt_q + 32'h1 : '0;
    end
    assign prot = (status_o[3:2] == 2'h3) || (status_o[3:2] == 2'h2 && mem_addr_o[13])
                  || (status_o[3:2] == 2'h1 && mem_addr_o[13:12] == 2'h3);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    commit_starts_busy_a: assert property (page_commit_o |=> status_o[0])
        else $error("busy did not follow commit");
    commit_needs_latch_a: assert property (page_commit_o |-> status_o[1])
        else $error("commit without write latch");
    load_when_idle_a: assert property (page_load_o |-> !status_o[0] && status_o[1])
        else $error("page load while busy or unlatched");
    busy_length_a: assert property ($fell(status_o[0]) |-> busy_cnt_q == WRITE_CYCLE_CYCLES)
        else $error("busy cycle length wrong");
    latch_clears_end_a: assert property ($fell(status_o[0]) |-> !status_o[1])
        else $error("latch still set after write cycle");
    protect_bits_change_a: assert property ($changed(status_o[7:2]) |-> $rose(status_o[0]))
        else $error("status bits changed outside status write");
    protect_range_a: assert property (page_commit_o && mem_space_o == 2'h0 |-> !prot)
        else $error("commit into protected range");
    oe_deselect_a: assert property (cs_b_i [*4] |-> !serial_out_oe_o)
        else $error("output driven while deselected");
    abort_quiet_a: assert property (page_abort_o |-> !page_commit_o ##1 !status_o[0])
        else $error("aborted frame started a write");
    latch_set_idle_a: assert property ($rose(status_o[1]) |-> !status_o[0])
        else $error("latch set while busy");
    commit_c: cover property (page_commit_o);
    abort_c: cover property (page_abort_o);
    lock_c: cover property ($rose(status_o[7]));
endmodule
bind spi_eeprom_instruction_engine spi_eeprom_instruction_engine_monitor #(
    .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) i_spi_eeprom_instruction_engine_monitor (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .serial_out_oe_o(serial_out_oe_o),
    .mem_addr_o(mem_addr_o), .mem_space_o(mem_space_o), .page_load_o(page_load_o),
    .page_commit_o(page_commit_o), .page_abort_o(page_abort_o), .status_o(status_o)
);
`default_nettype wire

/* File: bench/spi_host_model.sv */
/*
 * Mode 0 bus master: runs one framed transfer, returns the sampled output.
 * Assumes its lines change only at falling edges of clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic  clk_i,
    input wire logic  serial_out_i,
    output var logic  spi_clk_o,
    output var logic  cs_b_o,
    output var logic  serial_in_o
);
    initial begin
        spi_clk_o = 1'b0;
        cs_b_o = 1'b1;
        serial_in_o = 1'b0;
    end
    // 30 ns, landing on a falling edge of clk_i without racing its toggle
    task automatic half();
        #29;
        @(negedge clk_i);
    endtask
    // select held low for the whole frame, bits msb first
    task automatic frame(input int n, input logic [63:0] d, output logic [63:0] q);
        int i;
        q = '0;
        cs_b_o = 1'b0;
        half();
        for (i = n - 1; i >= 0; i--) begin
            serial_in_o = d[i];
            half();
            q = {q[62:0], serial_out_i};
            spi_clk_o = 1'b1;
            half();
            @(negedge clk_i);
            spi_clk_o = 1'b0;
        end
        half();
        cs_b_o = 1'b1;
        // released line shows the inverse of the last bit
        serial_in_o = ~serial_in_o;
        repeat (10) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

/* File: bench/spi_eeprom_instruction_engine_tb.sv */
/*
 * Self-checking bench: frames from the host model, array store as a
 * combinational function of the address.
 * Assumes the design files and the host model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_instruction_engine_tb;
    localparam int CYC = 2000;
    logic clk_i, rst_b_i, wp_b, locked;
    wire spi_clk, cs_b, serial_in, serial_out, oe, ld, commit, abort, slock;
    wire [15:0] mem_addr;
    wire [1:0] mem_space;
    wire [5:0] ld_idx;
    wire [7:0] ld_data, status;
    logic [7:0] rd_data;
    logic [41:0] ld_hist;
    logic [63:0] rx;
    int fail_count, checks, cyc, n_load, n_commit, n_abort, n_oe, n_slock, i;
    logic [15:0] a;

    spi_eeprom_instruction_engine #(.WRITE_CYCLE_CYCLES(20'd2000)) i_spi_eeprom_instruction_engine (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .spi_clk_i(spi_clk), .cs_b_i(cs_b),
        .serial_in_i(serial_in), .wp_b_i(wp_b), .serial_out_o(serial_out),
        .serial_out_oe_o(oe), .mem_addr_o(mem_addr), .mem_space_o(mem_space),
        .mem_rd_data_i(rd_data), .sector_locked_i(locked), .page_load_o(ld),
        .page_load_idx_o(ld_idx), .page_load_data_o(ld_data), .page_commit_o(commit),
        .page_abort_o(abort), .sector_lock_o(slock), .status_o(status));
    spi_host_model i_spi_host_model (.clk_i(clk_i), .serial_out_i(serial_out),
        .spi_clk_o(spi_clk), .cs_b_o(cs_b), .serial_in_o(serial_in));
    assign rd_data = mem_addr[7:0] ^ mem_addr[15:8];

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (ld) ld_hist <= {ld_hist[27:0], ld_idx, ld_data};
        n_load += ld;
        n_commit += commit;
        n_abort += abort;
        n_oe += oe;
        n_slock += slock;
        if (cyc == 60000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input int n, input logic [63:0] d);
        i_spi_host_model.frame(n, d, rx);
    endtask
    task automatic clr();
        {n_load, n_commit, n_abort, n_oe, n_slock} = '0;
    endtask
    task automatic idle();
        repeat (CYC + 100) @(negedge clk_i);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        {rst_b_i, fail_count, checks, cyc} = '0;
        wp_b = 1'b1;
        locked = 1'b1;
        ld_hist = '0;
        clr();
        repeat (16) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (5) @(negedge clk_i);
        chk(status, 8'h00);
        chk(oe, 1'b0);
        xfer(8, 8'h06);
        chk(status, 8'h02);
        xfer(16, 16'h0500);
        chk(rx[7:0], 8'h02);
        xfer(8, 8'h04);
        chk(status, 8'h00);
        xfer(32, 32'h02010000);
        chk(n_commit, 0);
        done("latch");
        xfer(8, 8'h06);
        xfer(48, {8'h02, 16'h013E, 8'h11, 8'h22, 8'h33});
        chk(ld_hist, {6'h3E, 8'h11, 6'h3F, 8'h22, 6'h00, 8'h33});
        chk(n_commit, 1);
        chk(status, 8'h03);
        xfer(24, 24'h050000);
        chk(rx[15:0], 16'h0303);
        clr();
        xfer(40, 40'h0300000000);
        chk(n_oe, 0);
        xfer(8, 8'h06);
        chk(status, 8'h03);
        idle();
        chk(status, 8'h00);
        done("page");
        xfer(8, 8'h06);
        clr();
        xfer(35, {8'h02, 16'h0000, 8'h55, 3'h5});
        chk({n_abort, n_commit}, {32'h1, 32'h0});
        xfer(17, {8'h01, 8'hFF, 1'b0});
        chk(status, 8'h02);
        xfer(16, 16'h01FF);
        chk(status, 8'h8F);
        idle();
        chk(status, 8'h8C);
        done("status");
        xfer(8, 8'h06);
        clr();
        xfer(32, 32'h02000077);
        chk({n_load, n_commit}, '0);
        wp_b = 1'b0;
        xfer(16, 16'h0100);
        chk(status, 8'h8E);
        wp_b = 1'b1;
        xfer(16, 16'h0104);
        idle();
        chk(status, 8'h04);
        for (i = 0; i < 2; i++) begin
            a = i ? 16'h3000 : 16'h2FC0;
            clr();
            xfer(8, 8'h06);
            xfer(32, {8'h02, a, 8'h99});
            idle();
            chk(n_commit, a[13:12] != 2'h3);
        end
        done("protect");
        xfer(40, 40'h0312340000);
        chk(rx[15:0], 16'h2627);
        xfer(40, 40'h83020F0000);
        chk({mem_space, rx[15:0]}, {2'h2, 16'h0D02});
        locked = 1'b0;
        clr();
        xfer(8, 8'h06);
        xfer(32, 32'h82040002);
        chk({n_slock, status}, {32'h1, 8'h07});
        idle();
        locked = 1'b1;
        xfer(40, 40'h8304000000);
        chk(rx[15:0], 16'h0202);
        clr();
        xfer(24, 24'hAA0000);
        chk(n_oe, 0);
        done("read");
        conclude();
    end
endmodule
`default_nettype wire
